//--- shared/erp_defines.svh
// Constants for the effect recall panel
`ifndef ERP_DEFINES_SVH
`define ERP_DEFINES_SVH
`define ERP_PAGE_COUNT 3'h5
`define ERP_PAGE_SIZE 7'h14
`define ERP_BUTTON_COUNT 5'h14
`define ERP_RUN_LAMP_MS 1000
`define ERP_CLK_HZ 125000000
`define ERP_RUN_LAMP_CYCLES ((`ERP_CLK_HZ / 1000) * `ERP_RUN_LAMP_MS)
`define ERP_BANK_MASTER 2'h0
`define ERP_BANK_ME1 2'h1
`define ERP_BANK_ME2 2'h2
`define ERP_BANK_ME3 2'h3
`endif

//--- shared/erp_pkg.sv
// Types for the effect recall panel
package erp_pkg;
    typedef enum logic [1:0] {
        ERP_NORMAL,
        ERP_PAGE_SEL,
        ERP_VERSION,
        ERP_RESET_HOLD
    } erp_mode_t;

    typedef struct packed {
        logic recall;
        logic run;
        logic [1:0] bank;
        logic [6:0] index;
    } erp_cmd_t;

    typedef struct packed {
        logic [1:0] bank;
        logic [2:0] page;
        logic [6:0] index;
        logic indexValid;
        logic showVersion;
        logic blank;
    } erp_readout_t;

    typedef struct packed {
        erp_mode_t mode;
        logic [1:0] bank;
        logic [2:0] page;
        logic [6:0] index;
        logic indexValid;
        logic autoRun;
        logic [27:0] lampCount;
        erp_cmd_t cmd;
    } erp_state_t;
endpackage : erp_pkg

//--- verilog/erp_effect_recall_panel.sv
// Effect recall panel control logic
//
// Operation
// R1 - Bank delegation buttons are mutually exclusive
// R2 - Repress clears; none lit targets master memory
// R3 - After page key accept digit 0 to 4
// R4 - Index equals page times twenty plus button
// R5 - Twenty buttons select registers in bank, page
// R6 - Auto run also runs selected register; the code runs it only while master is delegated
// R7 - Selected page is retained for later presses
// R8 - Run key runs selected master register
// R9 - Run lamp lights one second after command
// R10 - Run keys ignored while a bank delegated
// R11 - Page mode run plus auto resets panel
// R12 - Page mode third bank shows versions
// R13 - Digit zero leaves version display
// R14 - Readout shows bank, page, last register
// R15 - Switcher chooses levels by stored-level setting
// R16 - After switcher reset panel needs reset
// R17 - Each selection sends one recall command
`timescale 1ns/100ps
`include "erp_defines.svh"

module erp_effect_recall_panel
    import erp_pkg::*;
#(
    parameter int RUN_LAMP_CYCLES = `ERP_RUN_LAMP_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [2:0] bankKey,
    input wire logic pageKey,
    input wire logic digitValid,
    input wire logic [4:0] digit,
    input wire logic runKey,
    input wire logic autoRunKey,
    input wire logic runKeyHeld,
    input wire logic autoRunKeyHeld,
    output erp_cmd_t cmd,
    output logic runLamp,
    output logic autoRunLamp,
    output logic [2:0] bankLamp,
    output erp_readout_t readout
);
    initial begin
        if (RUN_LAMP_CYCLES < 1 || RUN_LAMP_CYCLES > 28'hfffffff) begin
            $error("RUN_LAMP_CYCLES out of range");
        end
    end

    erp_state_t stateReg;
    erp_state_t stateNext;

    function automatic logic [6:0] absIndex(input logic [2:0] page, input logic [4:0] button);
        absIndex = 7'(page * `ERP_PAGE_SIZE) + 7'(button);
    endfunction : absIndex

    function automatic logic [1:0] pressBank(input logic [1:0] cur, input logic [2:0] keys);
        logic [1:0] hit;
        hit = cur;
        if (keys[0]) begin
            hit = `ERP_BANK_ME1;
        end else if (keys[1]) begin
            hit = `ERP_BANK_ME2;
        end else if (keys[2]) begin
            hit = `ERP_BANK_ME3;
        end
        pressBank = (hit == cur) ? `ERP_BANK_MASTER : hit;
    endfunction : pressBank

    logic masterDelegated;
    assign masterDelegated = (stateReg.bank == `ERP_BANK_MASTER);

    always_comb begin
        stateNext = stateReg;
        stateNext.cmd = '0;
        if (stateReg.lampCount != '0) begin
            stateNext.lampCount = stateReg.lampCount - 28'h1;
        end
        case (stateReg.mode)
            ERP_NORMAL: begin
                if (pageKey) begin
                    stateNext.mode = ERP_PAGE_SEL;
                end else if (bankKey != 3'h0) begin
                    stateNext.bank = pressBank(stateReg.bank, bankKey); // R1 R2
                end else if (digitValid && digit < `ERP_BUTTON_COUNT) begin
                    stateNext.index = absIndex(stateReg.page, digit); // R4 R5 R7
                    stateNext.indexValid = 1'b1;
                    stateNext.cmd.recall = 1'b1; // R17
                    stateNext.cmd.bank = stateReg.bank;
                    stateNext.cmd.index = absIndex(stateReg.page, digit);
                    if (stateReg.autoRun && masterDelegated) begin
                        stateNext.cmd.run = 1'b1; // R6
                        stateNext.lampCount = 28'(RUN_LAMP_CYCLES);
                    end
                end else if (runKey && masterDelegated) begin // R10
                    stateNext.cmd.run = 1'b1; // R8
                    stateNext.cmd.bank = `ERP_BANK_MASTER;
                    stateNext.cmd.index = stateReg.index;
                    stateNext.lampCount = 28'(RUN_LAMP_CYCLES); // R9
                end else if (autoRunKey && masterDelegated) begin // R10
                    stateNext.autoRun = !stateReg.autoRun;
                end
            end
            ERP_PAGE_SEL: begin
                if (runKeyHeld && autoRunKeyHeld) begin
                    stateNext.mode = ERP_RESET_HOLD; // R11
                end else if (bankKey[2]) begin
                    stateNext.mode = ERP_VERSION; // R12
                end else if (digitValid && digit < 5'(`ERP_PAGE_COUNT)) begin
                    stateNext.page = digit[2:0]; // R3
                    stateNext.mode = ERP_NORMAL;
                end
            end
            ERP_VERSION: begin
                if (digitValid && digit == 5'h0) begin
                    stateNext.mode = ERP_NORMAL; // R13
                end
            end
            ERP_RESET_HOLD: begin
                // Panel restarts from its reset state once both keys are let go
                if (!runKeyHeld && !autoRunKeyHeld) begin
                    stateNext = '0; // R11 R16
                    stateNext.mode = ERP_NORMAL;
                end
            end
            default: begin
                stateNext.mode = ERP_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign cmd = stateReg.cmd;
    assign runLamp = (stateReg.lampCount != '0); // R9
    assign autoRunLamp = stateReg.autoRun;
    assign bankLamp = {stateReg.bank == `ERP_BANK_ME3, stateReg.bank == `ERP_BANK_ME2,
                       stateReg.bank == `ERP_BANK_ME1};
    always_comb begin
        readout.bank = stateReg.bank; // R14
        readout.page = stateReg.page;
        readout.index = stateReg.index;
        readout.indexValid = stateReg.indexValid;
        readout.showVersion = (stateReg.mode == ERP_VERSION);
        readout.blank = (stateReg.mode == ERP_RESET_HOLD);
    end

    // Checks sample registered state, so each one reads the decision of the previous edge

    // Delegation
    chk_lamps_exclusive: assert property (@(posedge clk) disable iff (!arst_n) // R1
        $onehot0(bankLamp))
        else $error("delegation lamps not exclusive");

    chk_repress_clears: assert property (@(posedge clk) disable iff (!arst_n) // R2
        (stateReg.mode == ERP_NORMAL && !pageKey && $onehot(bankKey) && bankLamp == bankKey)
        |=> stateReg.bank == `ERP_BANK_MASTER)
        else $error("repress did not return to master");

    chk_lamps_master: assert property (@(posedge clk) disable iff (!arst_n) // R2
        (bankLamp == 3'h0) == masterDelegated)
        else $error("dark lamps do not mean master delegation");

    chk_master_target: assert property (@(posedge clk) disable iff (!arst_n) // R2
        (cmd.recall && $past(masterDelegated))
        |-> cmd.bank == `ERP_BANK_MASTER)
        else $error("recall not aimed at master memory");

    chk_bank_follows: assert property (@(posedge clk) disable iff (!arst_n) // R1
        (stateReg.mode == ERP_NORMAL && !pageKey && bankKey != 3'h0)
        |=> readout.bank != $past(readout.bank))
        else $error("delegation press had no effect");

    // Paging
    chk_page_range: assert property (@(posedge clk) disable iff (!arst_n) // R3
        stateReg.page < `ERP_PAGE_COUNT)
        else $error("page out of range");

    chk_page_digit: assert property (@(posedge clk) disable iff (!arst_n) // R3
        (stateReg.mode == ERP_PAGE_SEL && !(runKeyHeld && autoRunKeyHeld) && !bankKey[2] && digitValid
        && digit < 5'(`ERP_PAGE_COUNT)) |=> (stateReg.page == $past(digit[2:0]) && stateReg.mode == ERP_NORMAL))
        else $error("page digit not taken");

    chk_page_refuse: assert property (@(posedge clk) disable iff (!arst_n) // R3
        (stateReg.mode == ERP_PAGE_SEL && !runKeyHeld && !bankKey[2] && digitValid
        && digit >= 5'(`ERP_PAGE_COUNT)) |=> (stateReg.mode == ERP_PAGE_SEL && $stable(stateReg.page)))
        else $error("out of range page digit taken");

    chk_page_retained: assert property (@(posedge clk) disable iff (!arst_n) // R7
        stateReg.mode == ERP_NORMAL
        |=> $stable(stateReg.page))
        else $error("page lost in normal operation");

    // Register selection and recall
    chk_recall_index: assert property (@(posedge clk) disable iff (!arst_n) // R4
        cmd.recall
        |-> cmd.index == absIndex($past(stateReg.page), $past(digit)))
        else $error("recall index wrong");

    chk_index_bound: assert property (@(posedge clk) disable iff (!arst_n) // R5
        cmd.recall
        |-> cmd.index < 7'(`ERP_PAGE_COUNT * `ERP_PAGE_SIZE))
        else $error("recall index above 99");

    chk_index_rejects: assert property (@(posedge clk) disable iff (!arst_n) // R5
        (stateReg.mode == ERP_NORMAL && !pageKey && bankKey == 3'h0 && digitValid && digit >= `ERP_BUTTON_COUNT)
        |=> !cmd.recall)
        else $error("button beyond nineteen recalled");

    chk_recall_needs_key: assert property (@(posedge clk) disable iff (!arst_n) // R17
        cmd.recall
        |-> $past(digitValid))
        else $error("recall without register press");

    chk_one_recall: assert property (@(posedge clk) disable iff (!arst_n) // R17
        cmd.recall
        |=> !cmd.recall)
        else $error("recall longer than one cycle");

    chk_recall_bank: assert property (@(posedge clk) disable iff (!arst_n) // R17
        cmd.recall
        |-> cmd.bank == readout.bank)
        else $error("recall carries wrong bank");

    chk_quiet_modes: assert property (@(posedge clk) disable iff (!arst_n) // R17
        stateReg.mode != ERP_NORMAL
        |=> (!cmd.recall && !cmd.run))
        else $error("command sent outside normal mode");

    // Run, auto run and lamp
    chk_auto_run: assert property (@(posedge clk) disable iff (!arst_n) // R6
        (cmd.recall && $past(stateReg.autoRun) && cmd.bank == `ERP_BANK_MASTER)
        |-> cmd.run)
        else $error("auto run missing");

    chk_auto_toggle: assert property (@(posedge clk) disable iff (!arst_n) // R6
        (stateReg.mode == ERP_NORMAL && !pageKey && bankKey == 3'h0 && !digitValid && !runKey && autoRunKey
        && masterDelegated) |=> autoRunLamp != $past(autoRunLamp))
        else $error("auto run key did not toggle");

    chk_run_key: assert property (@(posedge clk) disable iff (!arst_n) // R8
        (stateReg.mode == ERP_NORMAL && !pageKey && bankKey == 3'h0 && !digitValid && runKey && masterDelegated)
        |=> (cmd.run && cmd.index == $past(stateReg.index)))
        else $error("run key did not run selected register");

    chk_run_master: assert property (@(posedge clk) disable iff (!arst_n) // R8 R10
        cmd.run
        |-> cmd.bank == `ERP_BANK_MASTER ##0 runLamp)
        else $error("run while bank delegated");

    chk_ignore_run: assert property (@(posedge clk) disable iff (!arst_n) // R10
        !masterDelegated
        |=> !cmd.run)
        else $error("run issued with a bank delegated");

    chk_ignore_auto: assert property (@(posedge clk) disable iff (!arst_n) // R10
        (!masterDelegated && stateReg.mode != ERP_RESET_HOLD)
        |=> $stable(autoRunLamp))
        else $error("auto run changed with a bank delegated");

    chk_lamp_load: assert property (@(posedge clk) disable iff (!arst_n) // R9
        cmd.run
        |-> stateReg.lampCount == 28'(RUN_LAMP_CYCLES))
        else $error("run lamp time not loaded");

    chk_lamp_count: assert property (@(posedge clk) disable iff (!arst_n) // R9
        (stateReg.lampCount != 28'h0 && stateReg.mode != ERP_RESET_HOLD)
        |=> (stateReg.lampCount == $past(stateReg.lampCount) - 28'h1 || cmd.run))
        else $error("run lamp count skipped");

    chk_lamp_holds: assert property (@(posedge clk) disable iff (!arst_n) // R9
        $rose(runLamp)
        |-> runLamp [*8])
        else $error("run lamp dropped early");

    // Keystroke reset, version display and readout
    chk_reset_blank: assert property (@(posedge clk) disable iff (!arst_n) // R11
        (stateReg.mode == ERP_PAGE_SEL && runKeyHeld && autoRunKeyHeld)
        |=> readout.blank)
        else $error("readout not blanked");

    chk_blank_holds: assert property (@(posedge clk) disable iff (!arst_n) // R11
        (stateReg.mode == ERP_RESET_HOLD && (runKeyHeld || autoRunKeyHeld))
        |=> readout.blank)
        else $error("readout unblanked while keys held");

    chk_reset_restore: assert property (@(posedge clk) disable iff (!arst_n) // R11 R16
        (stateReg.mode == ERP_RESET_HOLD && !runKeyHeld && !autoRunKeyHeld)
        |=> (!readout.blank && masterDelegated && stateReg.page == 3'h0 && !autoRunLamp))
        else $error("keystroke reset did not restore");

    chk_version_enter: assert property (@(posedge clk) disable iff (!arst_n) // R12
        (stateReg.mode == ERP_PAGE_SEL && !(runKeyHeld && autoRunKeyHeld) && bankKey[2])
        |=> readout.showVersion)
        else $error("version display not entered");

    chk_version_exit: assert property (@(posedge clk) disable iff (!arst_n) // R13
        (readout.showVersion && digitValid && digit == 5'h0)
        |=> !readout.showVersion)
        else $error("version display stuck");

    chk_version_holds: assert property (@(posedge clk) disable iff (!arst_n) // R13
        (readout.showVersion && !(digitValid && digit == 5'h0))
        |=> readout.showVersion)
        else $error("version display left early");

    chk_readout_index: assert property (@(posedge clk) disable iff (!arst_n) // R14
        cmd.recall
        |-> (readout.index == cmd.index && readout.indexValid))
        else $error("readout misses last register");
endmodule : erp_effect_recall_panel

//--- verif/erp_frame_model.sv
// Switcher frame stand-in that records recall commands from the panel
`timescale 1ns/100ps
module erp_frame_model
    import erp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire erp_cmd_t cmd,
    output logic [7:0] recallCount,
    output logic [6:0] lastIndex
);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            recallCount <= 8'h00;
            lastIndex <= 7'h00;
        // Level enables stay the frame's own choice; the command carries no level mask
        end else if (cmd.recall) begin
            recallCount <= recallCount + 8'h01;
            lastIndex <= cmd.index;
        end
    end
endmodule : erp_frame_model

//--- verif/erp_effect_recall_panel_bench.sv
// Self-checking bench for the effect recall panel
`timescale 1ns/100ps
module erp_effect_recall_panel_bench
    import erp_pkg::*;
;
    localparam int LAMP = 20;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] bankKey = 3'h0;
    logic pageKey = 1'b0;
    logic digitValid = 1'b0;
    logic [4:0] digit = 5'h00;
    logic runKey = 1'b0;
    logic autoRunKey = 1'b0;
    logic runKeyHeld = 1'b0;
    logic autoRunKeyHeld = 1'b0;
    erp_cmd_t cmd;
    logic runLamp;
    logic autoRunLamp;
    logic [2:0] bankLamp;
    erp_readout_t readout;
    logic [7:0] recallCount;
    logic [6:0] lastIndex;
    int errors = 0;
    int total_checks = 0;

    erp_effect_recall_panel #(.RUN_LAMP_CYCLES(LAMP)) uut (.clk(clk), .arst_n(arst_n), .bankKey(bankKey),
        .pageKey(pageKey), .digitValid(digitValid), .digit(digit), .runKey(runKey), .autoRunKey(autoRunKey),
        .runKeyHeld(runKeyHeld), .autoRunKeyHeld(autoRunKeyHeld), .cmd(cmd), .runLamp(runLamp),
        .autoRunLamp(autoRunLamp), .bankLamp(bankLamp), .readout(readout));
    erp_frame_model frame (.clk(clk), .arst_n(arst_n), .cmd(cmd), .recallCount(recallCount),
        .lastIndex(lastIndex));

    initial begin
        forever #4 clk = ~clk;
    end

    task check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    // One-cycle key pulse; the result is settled just after the sampling edge
    task press(input logic [2:0] b, input logic p, input logic dv, input logic [4:0] d, input logic r,
        input logic a);
        @(posedge clk);
        {bankKey, pageKey, digitValid, digit, runKey, autoRunKey} <= {b, p, dv, d, r, a};
        @(posedge clk);
        {bankKey, pageKey, digitValid, digit, runKey, autoRunKey} <= 12'h000;
        #1;
    endtask : press

    task sel(input logic [4:0] d);
        press(3'h0, 1'b0, 1'b1, d, 1'b0, 1'b0);
    endtask : sel

    task pg(input logic [4:0] d);
        press(3'h0, 1'b1, 1'b0, 5'h00, 1'b0, 1'b0);
        sel(d);
    endtask : pg

    task end_of_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        end_of_test;
    end

    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        pg(5'h01);
        sel(5'h05);
        check({5'h00, cmd}, {5'h00, 4'h8, 7'h19});
        sel(5'h13);
        check({5'h00, cmd}, {5'h00, 4'h8, 7'h27});
        check({6'h00, readout.page, readout.index}, {6'h00, 3'h1, 7'h27});
        pg(5'h05);
        sel(5'h04);
        sel(5'h00);
        check({5'h00, cmd}, {5'h00, 4'h8, 7'h50});
        sel(5'h14);
        check({5'h00, cmd}, 16'h0000);
        check({1'b0, lastIndex, recallCount}, {1'b0, 7'h50, 8'h03});
        $display("paging done");
        press(3'h1, 1'b0, 1'b0, 5'h00, 1'b0, 1'b0);
        press(3'h2, 1'b0, 1'b0, 5'h00, 1'b0, 1'b0);
        check({11'h000, readout.bank, bankLamp}, {11'h000, 2'h2, 3'h2});
        press(3'h0, 1'b0, 1'b0, 5'h00, 1'b1, 1'b0);
        check({5'h00, cmd}, 16'h0000);
        press(3'h0, 1'b0, 1'b0, 5'h00, 1'b0, 1'b1);
        check({14'h0000, autoRunLamp, runLamp}, 16'h0000);
        sel(5'h01);
        check({5'h00, cmd}, {5'h00, 4'ha, 7'h51});
        press(3'h2, 1'b0, 1'b0, 5'h00, 1'b0, 1'b0);
        check({11'h000, readout.bank, bankLamp}, 16'h0000);
        $display("delegation done");
        press(3'h0, 1'b0, 1'b0, 5'h00, 1'b1, 1'b0);
        check({4'h0, cmd, runLamp}, {4'h0, 4'h4, 7'h51, 1'b1});
        // Lamp time is fixed by the shortened parameter, not by the effect
        repeat (LAMP - 3) @(posedge clk);
        #1;
        check({15'h0000, runLamp}, 16'h0001);
        repeat (5) @(posedge clk);
        #1;
        check({15'h0000, runLamp}, 16'h0000);
        press(3'h0, 1'b0, 1'b0, 5'h00, 1'b0, 1'b1);
        sel(5'h02);
        check({4'h0, cmd, autoRunLamp}, {4'h0, 4'hc, 7'h52, 1'b1});
        $display("run done");
        press(3'h0, 1'b1, 1'b0, 5'h00, 1'b0, 1'b0);
        press(3'h4, 1'b0, 1'b0, 5'h00, 1'b0, 1'b0);
        check({15'h0000, readout.showVersion}, 16'h0001);
        sel(5'h00);
        check({15'h0000, readout.showVersion}, 16'h0000);
        $display("version done");
        press(3'h0, 1'b1, 1'b0, 5'h00, 1'b0, 1'b0);
        runKeyHeld <= 1'b1;
        autoRunKeyHeld <= 1'b1;
        for (int i = 0; i < 10 && readout.blank !== 1'b1; i++) @(posedge clk);
        check({15'h0000, readout.blank}, 16'h0001);
        runKeyHeld <= 1'b0;
        autoRunKeyHeld <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check({11'h000, readout.blank, autoRunLamp, readout.page}, 16'h0000);
        $display("keystroke reset done");
        end_of_test;
    end
endmodule : erp_effect_recall_panel_bench
